// [verilog/halfbridge_spi_pkg.sv]
`default_nettype none

package halfbridge_spi_pkg;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned NUM_CTL = 10;
  localparam int unsigned NUM_STAT = 5;

  // ---------------------------------------------------------------
  // frame position counts (serial clock rising edges)
  // ---------------------------------------------------------------
  localparam logic [4:0] CNT_FIRST = 5'h00;
  localparam logic [4:0] CNT_ADDR_LAST = 5'h07;
  localparam logic [4:0] CNT_DATA_FIRST = 5'h08;
  localparam logic [4:0] CNT_FRAME_LAST = 5'h0f;
  localparam logic [4:0] CNT_FRAME_DONE = 5'h10;

  // ---------------------------------------------------------------
  // address byte fields
  // ---------------------------------------------------------------
  localparam int unsigned ACCESS_BIT = 7;
  localparam int unsigned SEL_HI = 6;
  localparam int unsigned SEL_LO = 2;
  localparam int unsigned TOKEN_BIT = 1;
  localparam int unsigned FIXED_BIT = 0;

  localparam logic [4:0] SEL_ACT_LO = 5'h00;
  localparam logic [4:0] SEL_ACT_HI = 5'h10;
  localparam logic [4:0] SEL_MODE_LO = 5'h18;
  localparam logic [4:0] SEL_MODE_HI = 5'h04;
  localparam logic [4:0] SEL_FREQ = 5'h0c;
  localparam logic [4:0] SEL_DUTY_ONE = 5'h1c;
  localparam logic [4:0] SEL_DUTY_TWO = 5'h02;
  localparam logic [4:0] SEL_DUTY_THREE = 5'h12;
  localparam logic [4:0] SEL_IDENTITY = 5'h19;
  localparam logic [4:0] SEL_OVP_FAST = 5'h03;
  localparam logic [4:0] SEL_RSVD_A = 5'h13;
  localparam logic [4:0] SEL_OL_DT_SR = 5'h07;
  localparam logic [4:0] SEL_RSVD_B = 5'h17;
  localparam logic [4:0] SEL_GLOBAL = 5'h06;
  localparam logic [4:0] SEL_OC_LO = 5'h16;
  localparam logic [4:0] SEL_OC_HI = 5'h0e;
  localparam logic [4:0] SEL_OL_LO = 5'h01;
  localparam logic [4:0] SEL_OL_HI = 5'h11;

  // ---------------------------------------------------------------
  // storage slots
  // ---------------------------------------------------------------
  localparam logic [3:0] SLOT_ACT_LO = 4'h0;
  localparam logic [3:0] SLOT_ACT_HI = 4'h1;
  localparam logic [3:0] SLOT_MODE_LO = 4'h2;
  localparam logic [3:0] SLOT_MODE_HI = 4'h3;
  localparam logic [3:0] SLOT_FREQ = 4'h4;
  localparam logic [3:0] SLOT_DUTY_ONE = 4'h5;
  localparam logic [3:0] SLOT_DUTY_TWO = 4'h6;
  localparam logic [3:0] SLOT_DUTY_THREE = 4'h7;
  localparam logic [3:0] SLOT_OVP_FAST = 4'h8;
  localparam logic [3:0] SLOT_OL_DT_SR = 4'h9;
  localparam logic [3:0] SLOT_IDENTITY = 4'ha;
  localparam logic [3:0] SLOT_RSVD = 4'hb;
  localparam logic [3:0] SLOT_NONE = 4'hf;

  localparam logic [2:0] ST_GLOBAL = 3'h0;
  localparam logic [2:0] ST_OC_LO = 3'h1;
  localparam logic [2:0] ST_OC_HI = 3'h2;
  localparam logic [2:0] ST_OL_LO = 3'h3;
  localparam logic [2:0] ST_OL_HI = 3'h4;
  localparam logic [2:0] ST_NONE = 3'h7;

  // ---------------------------------------------------------------
  // field positions, masks, reset values
  // ---------------------------------------------------------------
  localparam int unsigned GS_SPI_ERR = 7;
  localparam int unsigned GS_UV = 5;
  localparam int unsigned GS_OV = 4;
  localparam int unsigned GS_POWER_ON = 3;
  localparam int unsigned GS_THERM_OFF = 2;
  localparam int unsigned GS_THERM_WARN = 1;
  localparam int unsigned OVP_EXT_BIT = 7;
  localparam int unsigned NEG_OL_BIT = 5;
  localparam int unsigned DEAD_TIME_BIT = 4;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_OVP_FAST = 8'hf0;
  localparam logic [7:0] MASK_OL_DT_SR = 8'h37;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;
  // raw global byte keeps a power-on flag where the wire shows its inverse
  localparam logic [7:0] STAT_GLOBAL_RESET = 8'h08;
endpackage : halfbridge_spi_pkg

`default_nettype wire

// [verilog/halfbridge_spi_register_map.sv]
`timescale 1ns/1ns
`default_nettype none

module halfbridge_spi_register_map #(
  parameter logic [3:0] DEVICE_IDENTITY = 4'h3 // arbitrary value
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic serial_clock,
  input wire logic chip_select_low,
  input wire logic serial_data_in,
  output logic serial_data_out,
  input wire logic [halfbridge_spi_pkg::BYTE_W-1:0] high_switch_overcurrent_flag,
  input wire logic [halfbridge_spi_pkg::BYTE_W-1:0] low_switch_overcurrent_flag,
  input wire logic [halfbridge_spi_pkg::BYTE_W-1:0] high_switch_openload_flag,
  input wire logic [halfbridge_spi_pkg::BYTE_W-1:0] low_switch_openload_flag,
  input wire logic supply_undervoltage_flag,
  input wire logic supply_overvoltage_flag,
  input wire logic thermal_shutdown_flag,
  input wire logic thermal_prewarning_flag,
  output logic [7:0] bridge_high_switch_enable,
  output logic [7:0] bridge_low_switch_enable,
  output logic [15:0] bridge_pwm_source_select,
  output logic [5:0] pwm_channel_frequency_select,
  output logic [1:0] clock_modulation_select,
  output logic [7:0] pwm_channel_duty_value_one,
  output logic [7:0] pwm_channel_duty_value_two,
  output logic [7:0] pwm_channel_duty_value_three,
  output logic extended_overvoltage_option,
  output logic [2:0] pwm_channel_fast_rate,
  output logic negative_openload_disable,
  output logic dead_time_select,
  output logic [2:0] slew_rate_select
);
  import halfbridge_spi_pkg::*;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] ctl_slot(input logic [4:0] sel);
    unique case (sel)
      SEL_ACT_LO: ctl_slot = SLOT_ACT_LO;
      SEL_ACT_HI: ctl_slot = SLOT_ACT_HI;
      SEL_MODE_LO: ctl_slot = SLOT_MODE_LO;
      SEL_MODE_HI: ctl_slot = SLOT_MODE_HI;
      SEL_FREQ: ctl_slot = SLOT_FREQ;
      SEL_DUTY_ONE: ctl_slot = SLOT_DUTY_ONE;
      SEL_DUTY_TWO: ctl_slot = SLOT_DUTY_TWO;
      SEL_DUTY_THREE: ctl_slot = SLOT_DUTY_THREE;
      SEL_OVP_FAST: ctl_slot = SLOT_OVP_FAST;
      SEL_OL_DT_SR: ctl_slot = SLOT_OL_DT_SR;
      SEL_IDENTITY: ctl_slot = SLOT_IDENTITY;
      SEL_RSVD_A, SEL_RSVD_B: ctl_slot = SLOT_RSVD;
      default: ctl_slot = SLOT_NONE;
    endcase
  endfunction : ctl_slot

  function automatic logic [2:0] stat_slot(input logic [4:0] sel);
    unique case (sel)
      SEL_GLOBAL: stat_slot = ST_GLOBAL;
      SEL_OC_LO: stat_slot = ST_OC_LO;
      SEL_OC_HI: stat_slot = ST_OC_HI;
      SEL_OL_LO: stat_slot = ST_OL_LO;
      SEL_OL_HI: stat_slot = ST_OL_HI;
      default: stat_slot = ST_NONE;
    endcase
  endfunction : stat_slot

  // reserved bit positions never take written data
  function automatic logic [7:0] write_mask(input logic [3:0] slot);
    unique case (slot)
      SLOT_OVP_FAST: write_mask = MASK_OVP_FAST;
      SLOT_OL_DT_SR: write_mask = MASK_OL_DT_SR;
      default: write_mask = MASK_FULL;
    endcase
  endfunction : write_mask

  // high side of each bridge in the odd bit, low side in the even bit
  function automatic logic [7:0] pair_bits(input logic [3:0] hs, input logic [3:0] ls);
    pair_bits = 8'h00;
    for (int k = 0; k < 4; k++) begin
      pair_bits[2*k+1] = hs[k];
      pair_bits[2*k] = ls[k];
    end
  endfunction : pair_bits

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [4:0] cnt_ff;
  logic [7:0] addr_sr_ff;
  logic [7:0] data_sr_ff;
  logic [7:0] gsnap_ff;
  logic addr_ok_ff;
  logic [NUM_STAT-1:0][7:0] snap_ff;
  logic [NUM_STAT-1:0][7:0] sync1_ff;
  logic [NUM_STAT-1:0][7:0] sync2_ff;
  logic [NUM_STAT-1:0][7:0] sync3_ff;
  logic [NUM_STAT-1:0][7:0] view_ff;
  logic [7:0] ctl_ff [NUM_CTL];
  logic spi_err_ff;
  logic ctl_tgl_ff;
  logic clr_tgl_ff;
  logic [2:0] clr_idx_ff;
  logic [7:0] clr_mask_ff;
  logic sdo_ff;
  logic [NUM_STAT-1:0][7:0] stat_ff;
  logic [1:0] tgl_s1_ff;
  logic [1:0] tgl_s2_ff;
  logic [1:0] tgl_s3_ff;
  logic [1:0] tgl_seen_ff;

  // ---------------------------------------------------------------
  // link side: frame position and shifting
  // ---------------------------------------------------------------
  // chip select high holds the frame logic idle; the serial clock stops between frames
  wire frame_idle = rst | chip_select_low;
  wire [7:0] addr_full = {serial_data_in, addr_sr_ff[7:1]};
  wire [7:0] data_full = {serial_data_in, data_sr_ff[7:1]};
  wire [4:0] full_sel = addr_full[SEL_HI:SEL_LO];
  wire full_mapped = (ctl_slot(full_sel) != SLOT_NONE) || (stat_slot(full_sel) != ST_NONE);
  wire addr_good = addr_full[FIXED_BIT] & addr_full[TOKEN_BIT] & full_mapped;
  wire [4:0] sel = addr_sr_ff[SEL_HI:SEL_LO];
  wire modify_req = addr_sr_ff[ACCESS_BIT];
  wire [3:0] cslot = ctl_slot(sel);
  wire [2:0] sslot = stat_slot(sel);
  wire ctl_valid = cslot < SLOT_IDENTITY;
  wire stat_valid = sslot != ST_NONE;
  wire [3:0] cidx = ctl_valid ? cslot : SLOT_ACT_LO;
  wire [2:0] sidx = stat_valid ? sslot : ST_GLOBAL;
  wire last_edge = cnt_ff == CNT_FRAME_LAST;

  // global byte as seen on the wire; power-on flag shown inverted
  wire load_err = |{view_ff[ST_OC_LO], view_ff[ST_OC_HI], view_ff[ST_OL_LO], view_ff[ST_OL_HI]};
  wire [7:0] gword = {spi_err_ff, load_err, view_ff[ST_GLOBAL][GS_UV], view_ff[ST_GLOBAL][GS_OV],
                      ~view_ff[ST_GLOBAL][GS_POWER_ON], view_ff[ST_GLOBAL][GS_THERM_OFF],
                      view_ff[ST_GLOBAL][GS_THERM_WARN], 1'b0};
  wire global_fault_flag = |{gword[7:4], ~gword[GS_POWER_ON], gword[GS_THERM_OFF:GS_THERM_WARN]};

  always_ff @(posedge serial_clock or posedge frame_idle) begin
    if (frame_idle) begin
      cnt_ff <= CNT_FIRST;
      addr_sr_ff <= 8'h00;
      data_sr_ff <= 8'h00;
      gsnap_ff <= 8'h00;
      snap_ff <= '0;
      addr_ok_ff <= 1'b0;
    end else begin
      if (cnt_ff != CNT_FRAME_DONE) cnt_ff <= cnt_ff + 5'h01;
      if (cnt_ff < CNT_DATA_FIRST) addr_sr_ff <= addr_full;
      else if (cnt_ff <= CNT_FRAME_LAST) data_sr_ff <= data_full;
      // frozen at the first edge so later faults wait for the next frame
      if (cnt_ff == CNT_FIRST) gsnap_ff <= {gword[7:1], global_fault_flag};
      if (cnt_ff == CNT_ADDR_LAST) snap_ff <= view_ff;
      if (cnt_ff == CNT_ADDR_LAST) addr_ok_ff <= addr_good;
    end
  end

  // ---------------------------------------------------------------
  // link side: register file, read data, commands
  // ---------------------------------------------------------------
  // live status view so a fault arriving during the data byte shows in it
  wire [7:0] stat_read = (sidx == ST_GLOBAL) ? gword : view_ff[sidx];
  wire [7:0] ident_word = {4'h0, DEVICE_IDENTITY};
  wire [7:0] resp_live = ctl_valid ? ctl_ff[cidx] :
                         (cslot == SLOT_IDENTITY) ? ident_word :
                         stat_valid ? stat_read : 8'h00;
  wire new_fault = |(view_ff[sidx] & ~snap_ff[sidx]);
  wire do_write = last_edge & addr_ok_ff & modify_req & ctl_valid;
  wire do_clear = last_edge & addr_ok_ff & modify_req & stat_valid & ~new_fault;
  wire [7:0] wmask = write_mask(cidx);
  wire [7:0] nxt_word = (ctl_ff[cidx] & ~wmask) | (data_full & wmask);
  wire [NUM_STAT-1:0][7:0] agree = ~(sync2_ff ^ sync3_ff);
  wire [NUM_STAT-1:0][7:0] nxt_view = (sync3_ff & agree) | (view_ff & ~agree);
  wire nxt_sdo = (cnt_ff == CNT_FRAME_DONE) ? global_fault_flag :
                 (cnt_ff >= CNT_DATA_FIRST) ? resp_live[cnt_ff[2:0]] : gsnap_ff[cnt_ff[2:0]];

  always_ff @(posedge serial_clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_CTL; i++) ctl_ff[i] <= CTL_RESET;
      sync1_ff <= {{(NUM_STAT-1){STAT_RESET}}, STAT_GLOBAL_RESET};
      sync2_ff <= {{(NUM_STAT-1){STAT_RESET}}, STAT_GLOBAL_RESET};
      sync3_ff <= {{(NUM_STAT-1){STAT_RESET}}, STAT_GLOBAL_RESET};
      view_ff <= {{(NUM_STAT-1){STAT_RESET}}, STAT_GLOBAL_RESET};
      ctl_tgl_ff <= 1'b0;
      clr_tgl_ff <= 1'b0;
      clr_idx_ff <= ST_GLOBAL;
      clr_mask_ff <= 8'h00;
    end else begin
      sync1_ff <= stat_ff;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      view_ff <= nxt_view;
      if (do_write) ctl_ff[cidx] <= nxt_word;
      if (do_write) ctl_tgl_ff <= ~ctl_tgl_ff;
      if (do_clear) begin
        clr_idx_ff <= sidx;
        clr_mask_ff <= view_ff[sidx];
        clr_tgl_ff <= ~clr_tgl_ff;
      end
    end
  end

  // protocol error: set from the address byte, cleared with the global byte
  always_ff @(posedge serial_clock or posedge rst) begin
    if (rst) spi_err_ff <= 1'b0;
    else if (cnt_ff == CNT_ADDR_LAST && !addr_good) spi_err_ff <= 1'b1;
    else if (do_clear && sidx == ST_GLOBAL) spi_err_ff <= 1'b0;
  end

  // output changes on the falling edge, sampled by the master on the rising one
  always_ff @(negedge serial_clock or posedge rst) begin
    if (rst) sdo_ff <= 1'b1;
    else sdo_ff <= nxt_sdo;
  end

  assign serial_data_out = sdo_ff;

  // ---------------------------------------------------------------
  // system side: sticky fault bits and crossings
  // ---------------------------------------------------------------
  wire [NUM_STAT-1:0][7:0] events = {
    pair_bits(high_switch_openload_flag[7:4], low_switch_openload_flag[7:4]),
    pair_bits(high_switch_openload_flag[3:0], low_switch_openload_flag[3:0]),
    pair_bits(high_switch_overcurrent_flag[7:4], low_switch_overcurrent_flag[7:4]),
    pair_bits(high_switch_overcurrent_flag[3:0], low_switch_overcurrent_flag[3:0]),
    {2'b00, supply_undervoltage_flag, supply_overvoltage_flag, 1'b0,
     thermal_shutdown_flag, thermal_prewarning_flag, 1'b0}};
  wire [1:0] tgl_evt = ~(tgl_s2_ff ^ tgl_s3_ff) & (tgl_s3_ff ^ tgl_seen_ff);
  wire ctl_evt = tgl_evt[0];
  wire clr_evt = tgl_evt[1];
  logic [NUM_STAT-1:0][7:0] clear_vec;

  always_comb begin
    clear_vec = '0;
    for (int i = 0; i < NUM_STAT; i++) begin
      if (clr_evt && clr_idx_ff == 3'(i)) clear_vec[i] = clr_mask_ff;
    end
  end

  // an event in the clearing cycle wins over the clear
  wire [NUM_STAT-1:0][7:0] nxt_stat = (stat_ff & ~clear_vec) | events;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stat_ff <= {{(NUM_STAT-1){STAT_RESET}}, STAT_GLOBAL_RESET};
      tgl_s1_ff <= 2'b00;
      tgl_s2_ff <= 2'b00;
      tgl_s3_ff <= 2'b00;
      tgl_seen_ff <= 2'b00;
    end else begin
      stat_ff <= nxt_stat;
      tgl_s1_ff <= {clr_tgl_ff, ctl_tgl_ff};
      tgl_s2_ff <= tgl_s1_ff;
      tgl_s3_ff <= tgl_s2_ff;
      tgl_seen_ff <= tgl_seen_ff ^ tgl_evt;
    end
  end

  // ---------------------------------------------------------------
  // system side: control outputs
  // ---------------------------------------------------------------
  // control words are stable once the toggle is seen, so they are read whole here
  wire [15:0] enable_pairs = {ctl_ff[SLOT_ACT_HI], ctl_ff[SLOT_ACT_LO]};
  logic [7:0] nxt_high;
  logic [7:0] nxt_low;

  always_comb begin
    nxt_high = 8'h00;
    nxt_low = 8'h00;
    for (int k = 0; k < 8; k++) begin
      nxt_high[k] = enable_pairs[2*k+1] & ~enable_pairs[2*k];
      nxt_low[k] = enable_pairs[2*k] & ~enable_pairs[2*k+1];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bridge_high_switch_enable <= 8'h00;
      bridge_low_switch_enable <= 8'h00;
      bridge_pwm_source_select <= 16'h0000;
      pwm_channel_frequency_select <= 6'h00;
      clock_modulation_select <= 2'h0;
      pwm_channel_duty_value_one <= 8'h00;
      pwm_channel_duty_value_two <= 8'h00;
      pwm_channel_duty_value_three <= 8'h00;
      extended_overvoltage_option <= 1'b0;
      pwm_channel_fast_rate <= 3'h0;
      negative_openload_disable <= 1'b0;
      dead_time_select <= 1'b0;
      slew_rate_select <= 3'h0;
    end else if (ctl_evt) begin
      bridge_high_switch_enable <= nxt_high;
      bridge_low_switch_enable <= nxt_low;
      bridge_pwm_source_select <= {ctl_ff[SLOT_MODE_HI], ctl_ff[SLOT_MODE_LO]};
      pwm_channel_frequency_select <= ctl_ff[SLOT_FREQ][5:0];
      clock_modulation_select <= ctl_ff[SLOT_FREQ][7:6];
      pwm_channel_duty_value_one <= ctl_ff[SLOT_DUTY_ONE];
      pwm_channel_duty_value_two <= ctl_ff[SLOT_DUTY_TWO];
      pwm_channel_duty_value_three <= ctl_ff[SLOT_DUTY_THREE];
      extended_overvoltage_option <= ctl_ff[SLOT_OVP_FAST][OVP_EXT_BIT];
      pwm_channel_fast_rate <= ctl_ff[SLOT_OVP_FAST][6:4];
      negative_openload_disable <= ctl_ff[SLOT_OL_DT_SR][NEG_OL_BIT];
      dead_time_select <= ctl_ff[SLOT_OL_DT_SR][DEAD_TIME_BIT];
      slew_rate_select <= ctl_ff[SLOT_OL_DT_SR][2:0];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_unused_sets_err: assert property (@(posedge serial_clock) disable iff (rst)
    (cnt_ff == CNT_ADDR_LAST && !full_mapped) |=> spi_err_ff)
    else $error("unused address did not flag protocol error");
  chk_fixed_bit_err: assert property (@(posedge serial_clock) disable iff (rst)
    (cnt_ff == CNT_ADDR_LAST && !addr_full[FIXED_BIT]) |=> spi_err_ff && !addr_ok_ff)
    else $error("address with bit0 low was accepted");
  chk_gstat_frozen: assert property (@(posedge serial_clock) disable iff (frame_idle)
    (cnt_ff > 5'h01 && cnt_ff <= CNT_FRAME_LAST) |-> $stable(gsnap_ff))
    else $error("global byte changed inside a frame");
  chk_clear_skip_new: assert property (@(posedge serial_clock) disable iff (rst)
    (last_edge && addr_ok_ff && modify_req && stat_valid && new_fault) |=> $stable(clr_tgl_ff))
    else $error("clear issued although a new fault arrived");
  chk_plain_read_keeps: assert property (@(posedge serial_clock) disable iff (rst)
    (last_edge && !modify_req) |=> $stable(clr_tgl_ff) && $stable(ctl_tgl_ff))
    else $error("read only frame changed state");
  chk_id_write_ignored: assert property (@(posedge serial_clock) disable iff (rst)
    (last_edge && cslot == SLOT_IDENTITY) |=> $stable(ctl_tgl_ff))
    else $error("identity write was committed");
  chk_duty_write: assert property (@(posedge serial_clock) disable iff (rst)
    (last_edge && addr_ok_ff && modify_req && cslot == SLOT_DUTY_ONE)
      |=> ctl_ff[SLOT_DUTY_ONE] == $past(data_full))
    else $error("duty write not stored");
  chk_rsvd_reads_zero: assert property (@(posedge serial_clock) disable iff (frame_idle)
    (cnt_ff >= CNT_DATA_FIRST && cslot == SLOT_RSVD) |-> resp_live == 8'h00)
    else $error("reserved location read non zero");
  chk_sticky_set: assert property (@(posedge clock) disable iff (rst)
    1'b1 |=> (stat_ff & $past(events)) == $past(events))
    else $error("fault event lost");
  chk_cross_off: assert property (@(posedge clock) disable iff (rst)
    (ctl_evt && enable_pairs[5:4] == 2'b11)
      |=> !bridge_high_switch_enable[2] && !bridge_low_switch_enable[2])
    else $error("bridge driven with both switches enabled");
  chk_reset_zero: assert property (@(posedge clock) disable iff (rst)
    $fell(rst) |-> bridge_high_switch_enable == 8'h00 && pwm_channel_duty_value_one == 8'h00)
    else $error("control output not zero after reset");

  cov_write_frame: cover property (@(posedge serial_clock) disable iff (rst) do_write);
  cov_read_clear: cover property (@(posedge serial_clock) disable iff (rst) do_clear);
  cov_clear_skipped: cover property (@(posedge serial_clock) disable iff (rst)
    last_edge && addr_ok_ff && modify_req && stat_valid && new_fault);
  cov_protocol_error: cover property (@(posedge serial_clock) disable iff (rst)
    cnt_ff == CNT_ADDR_LAST && !addr_good);
endmodule : halfbridge_spi_register_map

`default_nettype wire

// [verif/spi_master_model.sv]
`timescale 1ns/1ns
`default_nettype none

module spi_master_model (
  output logic serial_clock,
  output logic chip_select_low,
  output logic serial_data_in,
  input wire logic serial_data_out
);
  // link clock stands still low between frames
  initial begin
    serial_clock = 1'b0;
    chip_select_low = 1'b1;
    serial_data_in = 1'b0;
  end

  // ----------------------------------------
  // one 16-bit frame, lsb first
  // ----------------------------------------
  // stall_ns parks the link clock low after data edge 8; a slow master
  task automatic frame(input logic [7:0] addr, input logic [7:0] data, input int stall_ns,
      output logic [7:0] glob, output logic [7:0] resp);
    logic [15:0] word;
    logic [15:0] seen;
    word = {data, addr};
    serial_data_in = 1'b0;
    chip_select_low = 1'b0;
    #3;
    for (int i = 0; i < 16; i++) begin
      serial_data_in = word[i];
      #3 serial_clock = 1'b1;
      seen[i] = serial_data_out;
      #3 serial_clock = 1'b0;
      if (i == 8) #(stall_ns);
    end
    #3 chip_select_low = 1'b1;
    // line left driven with the inverse of the last bit sent
    serial_data_in = ~serial_data_in;
    glob = seen[7:0];
    resp = seen[15:8];
  endtask : frame
endmodule : spi_master_model

`default_nettype wire

// [verif/halfbridge_spi_register_map_bench.sv]
`timescale 1ns/1ns
`default_nettype none

module halfbridge_spi_register_map_bench;
  import halfbridge_spi_pkg::*;
  logic clock, rst;
  wire logic sclk, cs_n, sdi, sdo;
  logic [7:0] hoc, loc, hol, lol, hen, len, d1, d2, d3, g, r;
  logic [3:0] sys;
  logic [2:0] fast, slew;
  logic ovp, negol, dead;
  logic [15:0] psel;
  logic [5:0] freq;
  logic [1:0] cmod;
  int err_total, checks_done;
  logic [4:0] sels [13] = '{SEL_ACT_LO, SEL_ACT_HI, SEL_MODE_LO, SEL_MODE_HI, SEL_FREQ,
    SEL_DUTY_ONE, SEL_DUTY_TWO, SEL_DUTY_THREE, SEL_IDENTITY, SEL_OVP_FAST, SEL_RSVD_A,
    SEL_OL_DT_SR, SEL_RSVD_B};
  logic [7:0] sys_bit [4] = '{8'h02, 8'h04, 8'h10, 8'h20};

  spi_master_model m (.serial_clock(sclk), .chip_select_low(cs_n), .serial_data_in(sdi),
    .serial_data_out(sdo));
  // identity 4'h5 is an arbitrary value
  halfbridge_spi_register_map #(.DEVICE_IDENTITY(4'h5)) dut (.clock(clock), .rst(rst),
    .serial_clock(sclk), .chip_select_low(cs_n), .serial_data_in(sdi), .serial_data_out(sdo),
    .high_switch_overcurrent_flag(hoc), .low_switch_overcurrent_flag(loc),
    .high_switch_openload_flag(hol), .low_switch_openload_flag(lol),
    .supply_undervoltage_flag(sys[3]), .supply_overvoltage_flag(sys[2]),
    .thermal_shutdown_flag(sys[1]), .thermal_prewarning_flag(sys[0]),
    .bridge_high_switch_enable(hen), .bridge_low_switch_enable(len),
    .bridge_pwm_source_select(psel), .pwm_channel_frequency_select(freq),
    .clock_modulation_select(cmod), .pwm_channel_duty_value_one(d1),
    .pwm_channel_duty_value_two(d2), .pwm_channel_duty_value_three(d3),
    .extended_overvoltage_option(ovp), .pwm_channel_fast_rate(fast),
    .negative_openload_disable(negol), .dead_time_select(dead), .slew_rate_select(slew));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask : chk

  // eight clocks after each frame covers the crossing and the 6-clock spacing
  task automatic xfer(input logic wr, input logic [4:0] sel, input logic [7:0] d,
      input int st = 0, input logic [1:0] tail = 2'b11);
    @(negedge clock);
    m.frame({wr, sel, tail}, d, st, g, r);
    repeat (8) @(negedge clock);
  endtask : xfer

  task automatic rd(input string n, input logic [4:0] sel, input logic [7:0] e);
    xfer(1'b0, sel, 8'h00);
    chk(n, {8'h00, e}, {8'h00, r});
  endtask : rd

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  initial begin
    #400000;
    err_total++;
    wrap_up();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    {hoc, loc, hol, lol, sys} = '0;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    repeat (2) @(negedge clock);
    chk("enables", 16'h0000, {hen, len});
    chk("pwm select", 16'h0000, psel);
    foreach (sels[i]) rd("reset value", sels[i], (sels[i] == SEL_IDENTITY) ? 8'h05 : 8'h00);
    chk("power on global", 16'h0001, {8'h00, g});
    xfer(1'b1, SEL_GLOBAL, 8'h00);
    rd("global", SEL_GLOBAL, 8'h08);
    $display("test reset done");
    xfer(1'b1, SEL_DUTY_ONE, 8'ha5);
    chk("global cleared", 16'h0008, {8'h00, g});
    chk("duty one", 16'h00a5, {8'h00, d1});
    rd("duty readback", SEL_DUTY_ONE, 8'ha5);
    chk("read keeps duty", 16'h00a5, {8'h00, d1});
    xfer(1'b1, SEL_ACT_LO, 8'h36);
    chk("bridge enables", 16'h0102, {hen, len});
    xfer(1'b1, SEL_MODE_LO, 8'h1b);
    chk("pwm select", 16'h001b, psel);
    xfer(1'b1, SEL_FREQ, 8'hc6);
    chk("frequency", 16'h00c6, {8'h00, cmod, freq});
    xfer(1'b1, SEL_IDENTITY, 8'hff);
    rd("identity", SEL_IDENTITY, 8'h05);
    xfer(1'b1, SEL_OVP_FAST, 8'hff);
    rd("option mask a", SEL_OVP_FAST, 8'hf0);
    chk("option outputs a", 16'h000f, {12'h000, ovp, fast});
    xfer(1'b1, SEL_OL_DT_SR, 8'hff);
    rd("option mask b", SEL_OL_DT_SR, 8'h37);
    chk("option outputs b", 16'h0037, {10'h000, negol, dead, 1'b0, slew});
    xfer(1'b1, SEL_DUTY_TWO, 8'h3c);
    xfer(1'b1, SEL_DUTY_THREE, 8'hc3);
    chk("duty two three", 16'h3cc3, {d2, d3});
    xfer(1'b1, SEL_RSVD_A, 8'hff);
    rd("reserved", SEL_RSVD_A, 8'h00);
    $display("test control done");
    xfer(1'b1, SEL_DUTY_ONE, 8'hff, 0, 2'b10);
    rd("bad frame ignored", SEL_DUTY_ONE, 8'ha5);
    chk("fixed bit error", 16'h0089, {8'h00, g});
    xfer(1'b1, SEL_GLOBAL, 8'h00);
    xfer(1'b1, 5'h1f, 8'hff);
    xfer(1'b0, SEL_GLOBAL, 8'h00);
    chk("protocol error", 16'h0089, {8'h00, g});
    for (int i = 0; i < 4; i++) begin
      sys = 4'h1 << i;
      @(negedge clock);
      sys = 4'h0;
      xfer(1'b1, SEL_GLOBAL, 8'h00);
      xfer(1'b1, SEL_GLOBAL, 8'h00);
      chk("supply flag", {8'h00, sys_bit[i] | 8'h09}, {8'h00, g});
    end
    $display("test global done");
    loc = 8'h01;
    lol = 8'h02;
    @(negedge clock);
    {loc, lol} = '0;
    xfer(1'b0, SEL_GLOBAL, 8'h00);
    rd("overcurrent", SEL_OC_LO, 8'h01);
    chk("load error", 16'h0049, {8'h00, g});
    rd("open load", SEL_OL_LO, 8'h04);
    xfer(1'b1, SEL_OC_LO, 8'h00);
    xfer(1'b1, SEL_OL_LO, 8'h00);
    rd("oc cleared", SEL_OC_LO, 8'h00);
    rd("ol cleared", SEL_OL_LO, 8'h00);
    fork
      xfer(1'b1, SEL_OC_LO, 8'h00, 200);
      begin
        repeat (3) @(negedge clock);
        hoc = 8'h08;
        @(negedge clock);
        hoc = 8'h00;
      end
    join
    chk("late fault response", 16'h0080, {8'h00, r});
    chk("late fault global", 16'h0008, {8'h00, g});
    rd("clear skipped", SEL_OC_LO, 8'h80);
    chk("next global", 16'h0049, {8'h00, g});
    $display("test faults done");
    @(negedge clock);
    rst = 1'b1;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    repeat (2) @(negedge clock);
    chk("reset again", 16'h0000, {hen, d1});
    rd("duty after reset", SEL_DUTY_ONE, 8'h00);
    $display("test reset again done");
    wrap_up();
  end
endmodule : halfbridge_spi_register_map_bench

`default_nettype wire
